// File: pts_defines.vh
// constants of the point table positioning sequencer
`ifndef PTS_DEFINES_VH
`define PTS_DEFINES_VH
`define PTS_ADR_CTRL 8'h00
`define PTS_ADR_MODE 8'h04
`define PTS_ADR_TARGET 8'h08
`define PTS_ADR_PT_ACT 8'h0C
`define PTS_ADR_MCODE_ACT 8'h10
`define PTS_ADR_STATUS 8'h14
`define PTS_ADR_IRQ_STAT 8'h18
`define PTS_ADR_IRQ_MASK 8'h1C
`define PTS_ADR_INP_RANGE 8'h20
`define PTS_ADR_CRP_RANGE 8'h24
`define PTS_ADR_PROC_SPEED 8'h28
`define PTS_ADR_PT_INDEX 8'h2C
`define PTS_ADR_PT_POS 8'h30
`define PTS_ADR_PT_DWELL 8'h34
`define PTS_ADR_PT_AUXM 8'h38
`define PTS_CTRL_NEWSP 4
`define PTS_MODE_PT 8'h9B
`define PTS_AUX_ABS_CHAIN 4'h1
`define PTS_AUX_REL_CHAIN 4'h3
`define PTS_AUX_REL_BIT 1
`define PTS_AUXM_MCODE_LSB 8
`define PTS_ST_INP 0
`define PTS_ST_CPO 1
`define PTS_ST_MEND 2
`define PTS_ST_BUSY 3
`define PTS_ST_CHAIN 4
`define PTS_IRQ_DONE 0
`define PTS_IRQ_REFUSED 1
`define PTS_IRQ_INP 2
`define PTS_IRQ_W 3
`define PTS_INP_RANGE_RST 32'h0000_0064
`define PTS_CRP_RANGE_RST 32'h0000_0000
`define PTS_MS_NS 1000000
`define PTS_CLK_NS 4
`endif

// File: pts_flag_unit.v
// in-position, rough-match and travel-completion flag logic
module pts_flag_unit (
	input wire clk_i,
	input wire rst_i,
	input wire [31:0] droop_i,
	input wire [31:0] remain_i,
	input wire [31:0] inp_range_i,
	input wire [31:0] crp_range_i,
	input wire chaining_i,
	output reg in_position_flag_o,
	output reg rough_match_flag_o,
	output reg travel_done_flag_o
);

	// signed distances compare by magnitude; most negative value saturates
	function [31:0] pts_abs;
		input [31:0] v;
		begin
			if (v[31])
				pts_abs = (v == 32'h8000_0000) ? 32'h7FFF_FFFF : (~v + 32'h0000_0001);
			else
				pts_abs = v;
		end
	endfunction

	wire inp_now;
	wire rem_zero;

	assign inp_now = (pts_abs(droop_i) <= inp_range_i);
	assign rem_zero = (remain_i == 32'h0000_0000);

	always @(posedge clk_i) begin
		if (rst_i) begin
			in_position_flag_o <= 1'b0;
			rough_match_flag_o <= 1'b0;
			travel_done_flag_o <= 1'b0;
		end else begin
			in_position_flag_o <= inp_now;
			rough_match_flag_o <= !chaining_i && (pts_abs(remain_i) <= crp_range_i);
			travel_done_flag_o <= !chaining_i && inp_now && rem_zero;
		end
	end

endmodule

// File: pts_motor_model.sv
// motion side model: runs a move of len_i cycles per start
module pts_motor_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [7:0] len_i,
	output logic still_o,
	output logic done_o = 1'b0,
	output logic [31:0] droop_o,
	output logic [31:0] remain_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] n_q = 8'h0;
	// droop twice the remainder so it crosses the in-position range
	assign droop_o = {23'h0, n_q, 1'b0};
	assign remain_o = {24'h0, n_q};
	assign still_o = n_q == 8'h0;
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rst_i) n_q <= 8'h0;
		else if (start_i) n_q <= len_i;
		else if (n_q != 8'h0) begin
			n_q <= n_q - 8'h1;
			done_o <= n_q == 8'h1;
		end
	end
endmodule

// File: pts_seq_checker.sv
// concurrent checks on the ports of the point table sequencer
module pts_seq_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic irq_o,
	input wire logic servo_on_i,
	input wire logic standstill_i,
	input wire logic [31:0] droop_i,
	input wire logic [31:0] remain_i,
	input wire logic move_start_o,
	input wire logic in_position_flag_o,
	input wire logic rough_match_flag_o,
	input wire logic travel_done_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// shadow ranges; assumes full-word writes, as the bench does
	logic [31:0] inp_q;
	logic [31:0] crp_q;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	always @(posedge clk_i) begin
		if (rst_i) begin
			inp_q <= 32'h64;
			crp_q <= 32'h0;
		end else if (cyc_i && stb_i && we_i && ack_o) begin
			if (adr_i == 8'h20) inp_q <= dat_i;
			if (adr_i == 8'h24) crp_q <= dat_i;
		end
	end
	AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not answered next cycle");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	AST_UNMAP: assert property (ack_o && !we_i && adr_i > 8'h3B |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_START_PULSE: assert property (move_start_o |=> !move_start_o)
		else $error("move start longer than one cycle");
	AST_START_STILL: assert property (move_start_o |-> $past(standstill_i, 3) && $past(servo_on_i, 3))
		else $error("move started while rotating or servo off");
	// past reset guard: the flag register still shows its reset value there
	AST_INP: assert property (!$past(rst_i) |-> in_position_flag_o == ($past(droop_i) <= $past(inp_q)))
		else $error("in-position flag wrong");
	AST_CRP: assert property (rough_match_flag_o |-> $past(remain_i) <= $past(crp_q))
		else $error("rough match outside range");
	AST_MEND: assert property (travel_done_flag_o |-> in_position_flag_o && $past(remain_i) == 32'h0)
		else $error("travel done without in-position at zero");
	cover property (move_start_o);
	cover property (travel_done_flag_o);
	cover property (irq_o);
endmodule
bind pts_sequencer pts_seq_checker u_chk(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
	.servo_on_i(servo_on_i), .standstill_i(standstill_i), .droop_i(droop_i), .remain_i(remain_i),
	.move_start_o(move_start_o), .in_position_flag_o(in_position_flag_o),
	.rough_match_flag_o(rough_match_flag_o), .travel_done_flag_o(travel_done_flag_o));

// File: pts_sequencer.v
// point table positioning sequencer with wishbone register slave
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`include "pts_defines.vh"

// Summary of operation
// - point and m-code readbacks keep old values until the move finishes
// - new set-point rising starts a move if idle, in point table mode, servo on and motor stopped
// - a new set-point while the motor rotates is ignored
// - in-position flag when droop magnitude is within the in-position range
// - rough-match flag when remaining distance is within the rough-match range
// - rough-match and travel-done stay low during chained operation
// - travel-done only when in-position and remaining distance is zero
// - one start runs consecutive entries one after another
// - entry chains when dwell is nonzero, aux is 1 or 3 and it is not the last table entry
// - non-chaining aux 0 is absolute, aux 2 is relative
module pts_sequencer #(
	parameter PT_DEPTH = 256,
	parameter CYC_PER_MS = `PTS_MS_NS / `PTS_CLK_NS
) (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	output wire irq_o,
	input wire servo_on_i,
	input wire standstill_i,
	input wire move_done_i,
	input wire [31:0] droop_i,
	input wire [31:0] remain_i,
	output reg move_start_o,
	output reg [31:0] move_target_o,
	output reg move_relative_o,
	output reg [7:0] point_demand_o,
	output reg command_process_speed_o,
	output wire in_position_flag_o,
	output wire rough_match_flag_o,
	output wire travel_done_flag_o
);

	localparam S_IDLE = 3'h0;
	localparam S_LOAD = 3'h1;
	localparam S_MOVE = 3'h2;
	localparam S_WAIT = 3'h3;
	localparam S_DWELL = 3'h4;

	reg [31:0] pos_mem [0:PT_DEPTH-1];
	reg [15:0] dwell_mem [0:PT_DEPTH-1];
	reg [3:0] aux_mem [0:PT_DEPTH-1];
	reg [7:0] mcode_mem [0:PT_DEPTH-1];

	reg [31:0] ctrl_q;
	reg [7:0] mode_q;
	reg [7:0] target_q;
	reg [7:0] pt_act_q;
	reg [7:0] mcode_act_q;
	reg [`PTS_IRQ_W-1:0] irq_stat_q;
	reg [`PTS_IRQ_W-1:0] irq_mask_q;
	reg [31:0] inp_range_q;
	reg [31:0] crp_range_q;
	reg [7:0] pt_index_q;
	reg newsp_prev_q;
	reg inp_prev_q;
	reg [2:0] state_q;
	reg [7:0] cur_q;
	reg cur_chain_q;
	reg [15:0] dwell_ms_q;
	reg [31:0] tick_q;
	reg wr_stb;
	reg [31:0] rd_d;
	reg [`PTS_IRQ_W-1:0] irq_set;
	reg [31:0] status_d;

	wire bus_req;
	wire newsp_rise;
	wire start_ok;
	wire entry_chains;
	wire [3:0] cur_aux;
	wire [15:0] cur_dwell;
	wire last_entry;

	// merge only the enabled byte lanes into an old register value
	function [31:0] pts_lanes;
		input [31:0] old;
		input [31:0] new_v;
		input [3:0] sel;
		integer k;
		begin
			pts_lanes = old;
			for (k = 0; k < 4; k = k + 1)
				if (sel[k])
					pts_lanes[k*8 +: 8] = new_v[k*8 +: 8];
		end
	endfunction

	assign bus_req = cyc_i && stb_i;
	assign cur_aux = aux_mem[cur_q];
	assign cur_dwell = dwell_mem[cur_q];
	assign entry_chains = (cur_dwell != 16'h0000) &&
		((cur_aux == `PTS_AUX_ABS_CHAIN) || (cur_aux == `PTS_AUX_REL_CHAIN));
	assign last_entry = (cur_q == PT_DEPTH[7:0] - 8'h01);
	assign newsp_rise = ctrl_q[`PTS_CTRL_NEWSP] && !newsp_prev_q;
	// refused while rotating: no edge is remembered for later
	assign start_ok = newsp_rise && (state_q == S_IDLE) && servo_on_i && standstill_i &&
		(mode_q == `PTS_MODE_PT);
	assign irq_o = |(irq_stat_q & irq_mask_q);

	always @* begin
		wr_stb = bus_req && we_i && ack_o;
	end

	// status bits placed by name so the map can move without touching the mux
	always @* begin
		status_d = 32'h0000_0000;
		status_d[`PTS_ST_INP] = in_position_flag_o;
		status_d[`PTS_ST_CPO] = rough_match_flag_o;
		status_d[`PTS_ST_MEND] = travel_done_flag_o;
		status_d[`PTS_ST_BUSY] = state_q != S_IDLE;
		status_d[`PTS_ST_CHAIN] = cur_chain_q && (state_q != S_IDLE);
	end

	always @* begin
		case (adr_i)
			`PTS_ADR_CTRL: rd_d = ctrl_q;
			`PTS_ADR_MODE: rd_d = {24'h000000, mode_q};
			`PTS_ADR_TARGET: rd_d = {24'h000000, target_q};
			`PTS_ADR_PT_ACT: rd_d = {24'h000000, pt_act_q};
			`PTS_ADR_MCODE_ACT: rd_d = {24'h000000, mcode_act_q};
			`PTS_ADR_STATUS: rd_d = status_d;
			`PTS_ADR_IRQ_STAT: rd_d = {29'h00000000, irq_stat_q};
			`PTS_ADR_IRQ_MASK: rd_d = {29'h00000000, irq_mask_q};
			`PTS_ADR_INP_RANGE: rd_d = inp_range_q;
			`PTS_ADR_CRP_RANGE: rd_d = crp_range_q;
			`PTS_ADR_PROC_SPEED: rd_d = {31'h00000000, command_process_speed_o};
			`PTS_ADR_PT_INDEX: rd_d = {24'h000000, pt_index_q};
			`PTS_ADR_PT_POS: rd_d = pos_mem[pt_index_q];
			`PTS_ADR_PT_DWELL: rd_d = {16'h0000, dwell_mem[pt_index_q]};
			`PTS_ADR_PT_AUXM: rd_d = {16'h0000, mcode_mem[pt_index_q], 4'h0, aux_mem[pt_index_q]};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// bus: ack one cycle after the request, writes land on the ack edge
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= bus_req && !ack_o;
			if (bus_req && !ack_o && !we_i)
				dat_o <= rd_d;
		end
	end

	// table memory has no reset; software loads it before use
	always @(posedge clk_i) begin
		if (wr_stb && adr_i == `PTS_ADR_PT_POS)
			pos_mem[pt_index_q] <= pts_lanes(pos_mem[pt_index_q], dat_i, sel_i);
		if (wr_stb && adr_i == `PTS_ADR_PT_DWELL && sel_i[0])
			dwell_mem[pt_index_q][7:0] <= dat_i[7:0];
		if (wr_stb && adr_i == `PTS_ADR_PT_DWELL && sel_i[1])
			dwell_mem[pt_index_q][15:8] <= dat_i[15:8];
		if (wr_stb && adr_i == `PTS_ADR_PT_AUXM && sel_i[0])
			aux_mem[pt_index_q] <= dat_i[3:0];
		if (wr_stb && adr_i == `PTS_ADR_PT_AUXM && sel_i[1])
			mcode_mem[pt_index_q] <= dat_i[`PTS_AUXM_MCODE_LSB +: 8];
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= 32'h0000_0000;
			mode_q <= 8'h00;
			target_q <= 8'h00;
			irq_mask_q <= {`PTS_IRQ_W{1'b0}};
			inp_range_q <= `PTS_INP_RANGE_RST;
			crp_range_q <= `PTS_CRP_RANGE_RST;
			pt_index_q <= 8'h00;
			command_process_speed_o <= 1'b0;
		end else if (wr_stb) begin
			case (adr_i)
				`PTS_ADR_CTRL: ctrl_q <= pts_lanes(ctrl_q, dat_i, sel_i);
				`PTS_ADR_MODE: if (sel_i[0]) mode_q <= dat_i[7:0];
				`PTS_ADR_TARGET: if (sel_i[0]) target_q <= dat_i[7:0];
				`PTS_ADR_IRQ_MASK: if (sel_i[0]) irq_mask_q <= dat_i[`PTS_IRQ_W-1:0];
				`PTS_ADR_INP_RANGE: inp_range_q <= pts_lanes(inp_range_q, dat_i, sel_i);
				`PTS_ADR_CRP_RANGE: crp_range_q <= pts_lanes(crp_range_q, dat_i, sel_i);
				`PTS_ADR_PROC_SPEED: if (sel_i[0]) command_process_speed_o <= dat_i[0];
				`PTS_ADR_PT_INDEX: if (sel_i[0]) pt_index_q <= dat_i[7:0];
				default: ;
			endcase
		end
	end

	// sticky events: a set in the clearing cycle survives the clear
	always @* begin
		irq_set = {`PTS_IRQ_W{1'b0}};
		irq_set[`PTS_IRQ_DONE] = (state_q == S_WAIT) && move_done_i && !cur_chain_q;
		irq_set[`PTS_IRQ_REFUSED] = newsp_rise && !start_ok;
		irq_set[`PTS_IRQ_INP] = in_position_flag_o && !inp_prev_q;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= {`PTS_IRQ_W{1'b0}};
			inp_prev_q <= 1'b0;
			newsp_prev_q <= 1'b0;
		end else begin
			inp_prev_q <= in_position_flag_o;
			newsp_prev_q <= ctrl_q[`PTS_CTRL_NEWSP];
			if (wr_stb && adr_i == `PTS_ADR_IRQ_STAT && sel_i[0])
				irq_stat_q <= (irq_stat_q & ~dat_i[`PTS_IRQ_W-1:0]) | irq_set;
			else
				irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
			cur_q <= 8'h00;
			cur_chain_q <= 1'b0;
			dwell_ms_q <= 16'h0000;
			tick_q <= 32'h0000_0000;
			pt_act_q <= 8'h00;
			mcode_act_q <= 8'h00;
			move_start_o <= 1'b0;
			move_target_o <= 32'h0000_0000;
			move_relative_o <= 1'b0;
			point_demand_o <= 8'h00;
		end else begin
			move_start_o <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (start_ok) begin
						cur_q <= target_q;
						state_q <= S_LOAD;
					end
				end
				S_LOAD: begin
					// chaining is judged per entry; aux bit 1 picks relative
					cur_chain_q <= entry_chains && !last_entry;
					move_target_o <= pos_mem[cur_q];
					move_relative_o <= cur_aux[`PTS_AUX_REL_BIT];
					point_demand_o <= cur_q;
					state_q <= S_MOVE;
				end
				S_MOVE: begin
					move_start_o <= 1'b1;
					state_q <= S_WAIT;
				end
				S_WAIT: begin
					if (move_done_i) begin
						pt_act_q <= cur_q;
						mcode_act_q <= mcode_mem[cur_q];
						if (cur_chain_q) begin
							dwell_ms_q <= cur_dwell;
							tick_q <= 32'h0000_0000;
							state_q <= S_DWELL;
						end else begin
							state_q <= S_IDLE;
						end
					end
				end
				S_DWELL: begin
					if (tick_q == CYC_PER_MS - 1) begin
						tick_q <= 32'h0000_0000;
						if (dwell_ms_q == 16'h0001) begin
							cur_q <= cur_q + 8'h01;
							state_q <= S_LOAD;
						end
						dwell_ms_q <= dwell_ms_q - 16'h0001;
					end else begin
						tick_q <= tick_q + 32'h0000_0001;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	pts_flag_unit u_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.droop_i(droop_i),
		.remain_i(remain_i),
		.inp_range_i(inp_range_q),
		.crp_range_i(crp_range_q),
		.chaining_i(cur_chain_q && (state_q != S_IDLE)),
		.in_position_flag_o(in_position_flag_o),
		.rough_match_flag_o(rough_match_flag_o),
		.travel_done_flag_o(travel_done_flag_o)
	);

endmodule

// File: pts_sequencer_tb.sv
// testbench of the point table positioning sequencer
`include "pts_defines.vh"
module pts_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, servo_on_i = 0, chn = 0;
	logic [7:0] adr_i = 0, len = 8'h28, point_demand_o;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 0, dat_o, droop_i, remain_i, move_target_o;
	logic ack_o, irq_o, standstill_i, move_done_i, move_start_o, move_relative_o, command_process_speed_o;
	logic in_position_flag_o, rough_match_flag_o, travel_done_flag_o;
	logic [31:0] rq[$], sq[$], pv[1:4];
	int error_cnt = 0, check_count = 0, cyc_n = 0, g = 0, k;
	logic [3:0] ax[1:4] = '{4'h1, 4'h3, 4'h0, 4'h2};
	always #2 clk_i = ~clk_i;
	pts_sequencer #(.CYC_PER_MS(4)) DUT(.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .irq_o, .servo_on_i, .standstill_i, .move_done_i, .droop_i, .remain_i, .move_start_o,
		.move_target_o, .move_relative_o, .point_demand_o, .command_process_speed_o, .in_position_flag_o,
		.rough_match_flag_o, .travel_done_flag_o);
	pts_motor_model u_mot(.clk_i, .rst_i, .start_i(move_start_o), .len_i(len), .still_o(standstill_i),
		.done_o(move_done_i), .droop_o(droop_i), .remain_o(remain_i));
	task results;
		if (error_cnt == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e, input string n);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
		@(posedge clk_i);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		wb(0, a, 32'h0);
	endtask
	task wait_irq;
		k = 0;
		while (irq_o !== 1'b1 && k < 3000) begin
			@(posedge clk_i);
			k++;
		end
		chk(k < 3000, 1, "irq wait");
		repeat (2) @(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		cyc_n++;
		g <= move_done_i ? 0 : g + 1;
		if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o, rq.pop_front(), "read data");
		if (move_start_o === 1'b1) begin
			chk(g >= 4, 1, "dwell gap");
			chk(move_target_o, pv[point_demand_o], "target");
			chk({move_relative_o, point_demand_o}, sq.size() ? sq.pop_front() : 32'hDEAD, "entry");
			if (point_demand_o === 8'h1) chn <= 1;
		end
		// between chained entries the motor is at zero, so only suppression keeps these low
		if (chn && remain_i == 0) begin
			if (point_demand_o === 8'h3) chn <= 0;
			else chk({rough_match_flag_o, travel_done_flag_o}, 0, "chain flags");
		end
		if (cyc_n == 20000) begin
			error_cnt++;
			results;
		end
	end
	initial begin
		void'($urandom(32'h8c40));
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		rd(`PTS_ADR_INP_RANGE, `PTS_INP_RANGE_RST);
		rd(8'h3C, 32'h0);
		wr(`PTS_ADR_MODE, {24'h0, `PTS_MODE_PT});
		wr(`PTS_ADR_PROC_SPEED, 32'h1);
		chk(command_process_speed_o, 1, "process speed");
		for (int i = 1; i < 5; i++) begin
			wr(`PTS_ADR_PT_INDEX, i);
			pv[i] = $urandom;
			wr(`PTS_ADR_PT_POS, pv[i]);
			wr(`PTS_ADR_PT_DWELL, i < 3);
			wr(`PTS_ADR_PT_AUXM, (i * 5 << 8) | ax[i]);
		end
		wr(`PTS_ADR_TARGET, 32'h1);
		wr(`PTS_ADR_CTRL, 32'h10);
		rd(`PTS_ADR_IRQ_STAT, 32'h6);
		wr(`PTS_ADR_CTRL, 32'h0);
		servo_on_i <= 1;
		wr(`PTS_ADR_IRQ_MASK, 32'h1);
		sq = '{32'h1, 32'h102, 32'h3};
		wr(`PTS_ADR_CTRL, 32'h10);
		rd(`PTS_ADR_PT_ACT, 32'h0);
		wait_irq;
		chk(travel_done_flag_o, 1, "travel done");
		chk(rough_match_flag_o, 1, "rough match");
		rd(`PTS_ADR_PT_ACT, 32'h3);
		rd(`PTS_ADR_MCODE_ACT, 32'hF);
		wr(`PTS_ADR_IRQ_MASK, 32'h0);
		chk(irq_o, 0, "irq masked");
		wr(`PTS_ADR_IRQ_MASK, 32'h1);
		chk(irq_o, 1, "irq unmasked");
		wr(`PTS_ADR_IRQ_STAT, 32'h1);
		chk(irq_o, 0, "irq cleared");
		len <= 8'hC8;
		wr(`PTS_ADR_CTRL, 32'h0);
		wr(`PTS_ADR_CRP_RANGE, 32'h8 + $urandom % 32'h40);
		wr(`PTS_ADR_TARGET, 32'h4);
		sq.push_back(32'h104);
		wr(`PTS_ADR_CTRL, 32'h10);
		wr(`PTS_ADR_CTRL, 32'h0);
		wr(`PTS_ADR_CTRL, 32'h10);
		wr(`PTS_ADR_PT_ACT, 32'h0);
		rd(`PTS_ADR_PT_ACT, 32'h3);
		wait_irq;
		rd(`PTS_ADR_PT_ACT, 32'h4);
		rd(`PTS_ADR_MCODE_ACT, 32'h14);
		chk({travel_done_flag_o, rough_match_flag_o}, 2'b11, "final flags");
		chk(sq.size(), 0, "starts left");
		results;
	end
endmodule
